// [shared/lfs_pkg.sv]
/*
 * constants, register map and carrier types of the led flash sequencer.
 * assumes a 20 mhz system clock and a classic wishbone master.
 */
package lfs_pkg;
    // clock and timing
    localparam int CLK_HZ       = 20_000_000;
    localparam int TICK_US      = 100;
    localparam int TICK_CYC     = CLK_HZ / 1_000_000 * TICK_US;
    localparam int STABLE_US    = 1000;
    localparam int STABLE_CYC   = CLK_HZ / 1_000_000 * STABLE_US;
    localparam int ON_MIN_NS    = 200;
    localparam int ON_MIN_CYC   = (ON_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int ON_MAX_MS    = 4900;
    localparam int ON_MAX_CYC   = CLK_HZ / 1000 * ON_MAX_MS;
    // frame rate in 0.1 hz units, period in ticks = DIV_NUM / rate
    localparam int RATE_MIN     = 2;
    localparam int RATE_MAX     = 100000;
    localparam int DIV_NUM      = 100000;
    localparam int DIV_BITS     = 18;
    // currents in ma
    localparam int CUR_MIN      = 200;
    localparam int CUR_MAX      = 2400;
    localparam int CUR_CONT_MAX = 500;
    localparam int BRK_FLASHES  = 5;
    localparam int BRK_MODES    = 5;
    // register offsets
    localparam logic [7:0] ADR_CTRL   = 8'h00;
    localparam logic [7:0] ADR_ONTIME = 8'h04;
    localparam logic [7:0] ADR_RATE   = 8'h08;
    localparam logic [7:0] ADR_COUNT  = 8'h0c;
    localparam logic [7:0] ADR_CUR    = 8'h10;
    localparam logic [7:0] ADR_STEP   = 8'h14;
    localparam logic [7:0] ADR_STATUS = 8'h18;
    localparam logic [7:0] ADR_PERIOD = 8'h1c;
    // control fields
    localparam int CTL_ON     = 0;
    localparam int CTL_EXT    = 1;
    localparam int CTL_BRK    = 2;
    localparam int CTL_CLR_OV = 8;
    // status fields
    localparam int ST_TEMP  = 0;
    localparam int ST_BOOST = 1;
    localparam int ST_BUCK  = 2;
    localparam int ST_FUSE  = 3;
    localparam int ST_LSW   = 4;
    localparam int ST_BUSY  = 5;
    localparam int ST_DIV   = 6;
    localparam int ST_FAIL  = 8;
    // bracketing factors, x256, per mode (1/4, 1/3, 1/2, 1, 2 stop)
    localparam logic [12:0] BRK_FACTOR [BRK_MODES][BRK_FLASHES] = '{
        '{13'h0b5, 13'h0d7, 13'h100, 13'h130, 13'h16a},
        '{13'h0a1, 13'h0cb, 13'h100, 13'h143, 13'h196},
        '{13'h080, 13'h0b5, 13'h100, 13'h16a, 13'h200},
        '{13'h040, 13'h080, 13'h100, 13'h200, 13'h400},
        '{13'h010, 13'h040, 13'h100, 13'h400, 13'h1000}};

    typedef enum logic [1:0] {
        FAIL_NONE = 2'h0, FAIL_TEMP = 2'h1, FAIL_BOOST_UV = 2'h2, FAIL_FUSE = 2'h3
    } lfs_fail_t;

    typedef enum logic [4:0] {
        SEQ_IDLE  = 5'h01, SEQ_CONT = 5'h02, SEQ_ARMED = 5'h04,
        SEQ_FLASH = 5'h08, SEQ_DONE = 5'h10
    } lfs_seq_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } lfs_wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } lfs_wb_rsp_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
        logic        state_on;
        logic        trig_ext;
        logic [2:0]  brk;
        logic [26:0] on_time;
        logic [16:0] rate;
        logic [15:0] period;
        logic [14:0] count;
        logic [11:0] cur_set;
        logic [11:0] cur_step;
        logic        boost_ovp;
        logic        buck_ovp;
        lfs_fail_t   fail;
        logic        load_sw;
        logic [15:0] stab_cnt;
        logic [10:0] tick_div;
        logic [15:0] frame_cnt;
        logic [26:0] width_cnt;
        logic [14:0] flashes;
        logic [2:0]  brk_idx;
        logic [11:0] cur_now;
        logic        trig_q;
        lfs_seq_t    seq;
        logic [4:0]  div_cnt;
        logic [17:0] div_num;
        logic [16:0] div_rem;
        logic        boost_en;
        logic        buck_en;
        logic [11:0] led_cur;
    } lfs_state_t;

    localparam lfs_state_t LFS_RST = '{seq: SEQ_IDLE, fail: FAIL_NONE, cur_set: 12'(CUR_MIN),
        trig_q: 1'b1, default: '0};
endpackage

// [verilog/lfs_sequencer.sv]
/*
 * led flash sequencer: register file, mode sequencer, fault latching
 * and converter enables.
 * assumes inputs synchronous to clk_i and a classic wishbone master.
 */
// Register access over Wishbone and the address map were decided locally.
module lfs_sequencer #(
    parameter int STABLE_CYCLES = lfs_pkg::STABLE_CYC
) (
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    input  wire lfs_pkg::lfs_wb_req_t wb_req_i,
    output lfs_pkg::lfs_wb_rsp_t     wb_rsp_o,
    input  wire logic                trig_n_i,
    input  wire logic [3:0]          temp_alert_n_i,
    input  wire logic                boost_ov_i,
    input  wire logic                buck_ov_i,
    input  wire logic                boost_uv_i,
    input  wire logic                fuse_fault_n_i,
    input  wire logic                supply_ok_i,
    output logic                     boost_en_o,
    output logic                     buck_en_o,
    output logic                     load_sw_en_o,
    output logic [11:0]              led_current_o
);
    import lfs_pkg::*;

    lfs_state_t  r;
    lfs_state_t  n;
    logic        tick;
    logic        over_temp;
    logic        cause;
    logic        kill;
    logic        trig_fall;
    logic        cont;
    logic        counted;
    logic [14:0] limit;
    logic        fire;
    logic        bus_hit;
    logic [17:0] div_sh;
    logic        div_ge;
    logic [31:0] wv;
    logic        clr_ov;

    // byte-lane merge of a write into the current word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return res;
    endfunction

    // flash width for bracketing mode and step, clamped to hardware range
    function automatic logic [26:0] scale(input logic [26:0] t, input logic [2:0] m,
                                          input logic [2:0] i);
        logic [39:0] p;
        p = 40'(t);
        if (m != 3'h0) begin
            p = (40'(t) * 40'(BRK_FACTOR[m - 3'h1][i])) >> 8;
        end
        if (p > 40'(ON_MAX_CYC)) begin
            p = 40'(ON_MAX_CYC);
        end
        if (p < 40'(ON_MIN_CYC)) begin
            p = 40'(ON_MIN_CYC);
        end
        return p[26:0];
    endfunction

    // clamp a value into a range
    function automatic logic [31:0] clamp(input logic [31:0] v, input int lo, input int hi);
        logic [31:0] res;
        res = v;
        if (v < 32'(lo)) begin
            res = 32'(lo);
        end
        if (v > 32'(hi)) begin
            res = 32'(hi);
        end
        return res;
    endfunction

    // live conditions
    assign tick      = r.tick_div == 11'(TICK_CYC - 1);
    assign over_temp = |(~temp_alert_n_i);
    assign cause     = over_temp | boost_uv_i | ~fuse_fault_n_i;
    assign kill      = cause | (r.fail != FAIL_NONE);
    assign trig_fall = r.trig_q & ~trig_n_i;
    assign cont      = r.rate == 17'h00000;
    assign counted   = (r.brk != 3'h0) || (r.count != 15'h0000);
    assign limit     = (r.brk != 3'h0) ? 15'(BRK_FLASHES) : r.count;
    assign fire      = r.trig_ext ? trig_fall : (tick && r.frame_cnt == 16'h0000 && r.div_cnt == 5'h00);
    assign bus_hit   = wb_req_i.cyc & wb_req_i.stb & ~r.ack;
    assign div_sh    = {r.div_rem, r.div_num[17]};
    assign div_ge    = div_sh >= {1'b0, r.rate};
    assign clr_ov    = bus_hit & wb_req_i.we & (wb_req_i.adr == ADR_CTRL) & wv[CTL_CLR_OV];

    // write data merged onto the addressed register
    always_comb begin
        wv = 32'h0000_0000;
        unique case (wb_req_i.adr)
            ADR_CTRL:   wv = merge(32'(r.brk) << CTL_BRK | 32'(r.trig_ext) << CTL_EXT
                               | 32'(r.state_on), wb_req_i.dat, wb_req_i.sel);
            ADR_ONTIME: wv = merge(32'(r.on_time), wb_req_i.dat, wb_req_i.sel);
            ADR_RATE:   wv = merge(32'(r.rate), wb_req_i.dat, wb_req_i.sel);
            ADR_COUNT:  wv = merge(32'(r.count), wb_req_i.dat, wb_req_i.sel);
            ADR_CUR:    wv = merge(32'(r.cur_set), wb_req_i.dat, wb_req_i.sel);
            ADR_STEP:   wv = merge(32'(r.cur_step), wb_req_i.dat, wb_req_i.sel);
            default:    wv = 32'h0000_0000;
        endcase
    end

    // next state of the whole block
    always_comb begin
        n = r;
        n.ack = 1'b0;
        n.trig_q = trig_n_i;
        n.tick_div = tick ? 11'h000 : r.tick_div + 11'h001;

        // period divider, one quotient bit per cycle
        if (r.div_cnt != 5'h00) begin
            n.div_rem = div_ge ? 17'(div_sh - {1'b0, r.rate}) : div_sh[16:0];
            n.div_num = {r.div_num[16:0], div_ge};
            n.div_cnt = r.div_cnt - 5'h01;
            if (r.div_cnt == 5'h01) begin
                n.period = (n.div_num[15:0] == 16'h0000) ? 16'h0001 : n.div_num[15:0];
            end
        end

        // wishbone slave: one ack per request, reads unmapped as zero
        if (bus_hit) begin
            n.ack = 1'b1;
            unique case (wb_req_i.adr)
                ADR_CTRL:   n.rdata = 32'(r.brk) << CTL_BRK | 32'(r.trig_ext) << CTL_EXT | 32'(r.state_on);
                ADR_ONTIME: n.rdata = 32'(r.on_time);
                ADR_RATE:   n.rdata = 32'(r.rate);
                ADR_COUNT:  n.rdata = 32'(r.count);
                ADR_CUR:    n.rdata = 32'(r.cur_set);
                ADR_STEP:   n.rdata = 32'(r.cur_step);
                ADR_STATUS: n.rdata = 32'(over_temp) << ST_TEMP | 32'(r.boost_ovp) << ST_BOOST
                                    | 32'(r.buck_ovp) << ST_BUCK | 32'(!fuse_fault_n_i) << ST_FUSE
                                    | 32'(r.load_sw) << ST_LSW
                                    | 32'(r.seq != SEQ_IDLE && r.seq != SEQ_DONE) << ST_BUSY
                                    | 32'(r.div_cnt != 5'h00) << ST_DIV
                                    | 32'(r.fail) << ST_FAIL;
                ADR_PERIOD: n.rdata = 32'(r.period);
                default:    n.rdata = 32'h0000_0000;
            endcase
            if (wb_req_i.we) begin
                unique case (wb_req_i.adr)
                    ADR_CTRL: begin
                        n.state_on = wv[CTL_ON];
                        if (!r.state_on) begin
                            n.trig_ext = wv[CTL_EXT];
                        end
                        n.brk = (wv[CTL_BRK +: 3] > 3'(BRK_MODES)) ? 3'h0 : wv[CTL_BRK +: 3];
                        if (wv[CTL_ON] && !r.state_on) begin
                            n.fail = FAIL_NONE;
                        end
                        if (clr_ov) begin
                            n.boost_ovp = 1'b0;
                            n.buck_ovp = 1'b0;
                        end
                    end
                    ADR_ONTIME: n.on_time = 27'(clamp(wv, ON_MIN_CYC, ON_MAX_CYC));
                    ADR_RATE: begin
                        if (wv == 32'h0000_0000) begin
                            n.rate = 17'h00000;
                            n.period = 16'h0000;
                            n.div_cnt = 5'h00;
                        end else begin
                            n.rate = 17'(clamp(wv, RATE_MIN, RATE_MAX));
                            n.div_num = 18'(DIV_NUM) + 18'(n.rate >> 1);
                            n.div_rem = 17'h00000;
                            n.div_cnt = 5'(DIV_BITS);
                        end
                    end
                    ADR_COUNT: n.count = wv[14:0];
                    ADR_CUR:   n.cur_set = 12'(clamp(wv, CUR_MIN, CUR_MAX));
                    ADR_STEP:  n.cur_step = wv[11:0];
                    default: ;
                endcase
            end
        end

        // overvoltage latches, set wins over clear
        if (boost_ov_i) begin
            n.boost_ovp = 1'b1;
        end
        if (buck_ov_i) begin
            n.buck_ovp = 1'b1;
        end

        // shutdown cause recording
        if (cause && n.fail == FAIL_NONE) begin
            n.fail = over_temp ? FAIL_TEMP : (boost_uv_i ? FAIL_BOOST_UV : FAIL_FUSE);
        end

        // load switch after the supply has stayed good
        if (!supply_ok_i) begin
            n.stab_cnt = 16'h0000;
            n.load_sw = 1'b0;
        end else if (r.stab_cnt >= 16'(STABLE_CYCLES - 1)) begin
            n.load_sw = 1'b1;
        end else begin
            n.stab_cnt = r.stab_cnt + 16'h0001;
        end

        // internal frame counter
        if (!r.trig_ext && tick && r.div_cnt == 5'h00 && (r.seq == SEQ_ARMED || r.seq == SEQ_FLASH)) begin
            n.frame_cnt = (r.frame_cnt == 16'h0000) ? r.period - 16'h0001 : r.frame_cnt - 16'h0001;
        end

        // flash sequencer
        if (!r.state_on || kill) begin
            n.seq = SEQ_IDLE;
        end else begin
            unique case (r.seq)
                SEQ_IDLE: begin
                    n.flashes = 15'h0000;
                    n.brk_idx = 3'h0;
                    n.cur_now = r.cur_set;
                    n.frame_cnt = 16'h0000;
                    n.seq = cont ? SEQ_CONT : SEQ_ARMED;
                end
                SEQ_CONT: begin
                    if (!cont) begin
                        n.seq = SEQ_ARMED;
                    end
                end
                SEQ_ARMED: begin
                    if (cont) begin
                        n.seq = SEQ_CONT;
                    end else if (fire) begin
                        n.seq = SEQ_FLASH;
                        n.width_cnt = scale(r.on_time, r.brk, r.brk_idx);
                    end
                end
                SEQ_FLASH: begin
                    n.width_cnt = r.width_cnt - 27'h1;
                    if (r.width_cnt <= 27'h1) begin
                        n.flashes = r.flashes + 15'h0001;
                        n.brk_idx = (r.brk_idx == 3'(BRK_FLASHES - 1)) ? 3'h0 : r.brk_idx + 3'h1;
                        if (r.count != 15'h0000) begin
                            n.cur_now = 12'(clamp(32'(r.cur_now) + 32'(r.cur_step), 0, CUR_MAX));
                        end
                        n.seq = (counted && n.flashes == limit) ? SEQ_DONE : SEQ_ARMED;
                    end
                end
                SEQ_DONE: begin
                    if (r.trig_ext && trig_fall && !cont) begin
                        n.flashes = 15'h0000;
                        n.brk_idx = 3'h0;
                        n.cur_now = r.cur_set;
                        n.seq = SEQ_FLASH;
                        n.width_cnt = scale(r.on_time, r.brk, 3'h0);
                    end
                end
                default: n.seq = SEQ_IDLE;
            endcase
        end

        // converter enables and current setpoint
        n.buck_en = (n.seq == SEQ_FLASH || (n.seq == SEQ_CONT && (!r.trig_ext || !trig_n_i)))
                    && n.state_on && !cause && n.fail == FAIL_NONE && !n.buck_ovp && n.load_sw;
        n.boost_en = n.load_sw && !n.boost_ovp && !cause && n.fail == FAIL_NONE;
        n.led_cur = (n.seq == SEQ_CONT) ? 12'(clamp(32'(r.cur_set), 0, CUR_CONT_MAX)) : n.cur_now;
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r <= LFS_RST;
        end else begin
            r <= n;
        end
    end

    // outputs straight from the state register
    assign wb_rsp_o      = '{ack: r.ack, dat: r.rdata};
    assign boost_en_o    = r.boost_en;
    assign buck_en_o     = r.buck_en;
    assign load_sw_en_o  = r.load_sw;
    assign led_current_o = r.led_cur;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_flash_last;
        r.seq == SEQ_FLASH && r.width_cnt == 27'h1 && r.state_on && !kill;
    endsequence

    sequence s_flash_over;
        r.seq != SEQ_FLASH && !buck_en_o;
    endsequence

    sequence s_ext_edge_armed;
        trig_fall && r.trig_ext && r.seq == SEQ_ARMED && r.state_on && !kill && !cont;
    endsequence

    chk_temp_kills_led: assert property (over_temp |=> !buck_en_o && r.fail != FAIL_NONE)
        else $error("led enable stayed on under over-temperature");
    chk_boost_ovp_latch: assert property (boost_ov_i |=> r.boost_ovp && !boost_en_o)
        else $error("boost overvoltage not latched");
    chk_buck_ovp_latch: assert property (buck_ov_i |=> r.buck_ovp && !buck_en_o)
        else $error("buck overvoltage not latched");
    chk_load_sw_supply: assert property (!supply_ok_i |=> !load_sw_en_o && !buck_en_o)
        else $error("load switch on without good supply");
    chk_fail_recorded: assert property (cause && r.fail == FAIL_NONE |=> r.fail != FAIL_NONE)
        else $error("shutdown cause not recorded");
    chk_fail_cleared: assert property ($rose(r.state_on) && !$past(cause) |-> r.fail == FAIL_NONE)
        else $error("fault not cleared on switch-on");
    chk_cont_current: assert property (r.seq == SEQ_CONT |-> led_current_o <= 12'(CUR_CONT_MAX))
        else $error("continuous current above limit");
    chk_flash_width_end: assert property (s_flash_last |=> s_flash_over)
        else $error("flash outlasted its width");
    chk_count_done: assert property (r.seq == SEQ_DONE && $past(r.seq) == SEQ_FLASH |-> r.flashes == limit && !buck_en_o)
        else $error("sequence stopped at wrong count");
    chk_trig_lock: assert property (r.state_on |=> $stable(r.trig_ext))
        else $error("trigger source changed while running");
    chk_off_no_light: assert property (!r.state_on |-> !buck_en_o)
        else $error("light on while state is off");

    // latch hold, trigger edge, switched, step, cause and period checks
    chk_boost_ovp_hold: assert property (r.boost_ovp && !clr_ov |=> r.boost_ovp)
        else $error("boost overvoltage latch lost");
    chk_buck_ovp_hold: assert property (r.buck_ovp && !clr_ov |=> r.buck_ovp)
        else $error("buck overvoltage latch lost");
    chk_ext_fall_fires: assert property (s_ext_edge_armed |=> r.seq == SEQ_FLASH)
        else $error("trigger edge did not start a flash");
    chk_switch_dark: assert property (r.seq == SEQ_CONT && r.trig_ext && trig_n_i |=> !buck_en_o)
        else $error("switched mode lit with trigger high");
    chk_step_counted: assert property (r.seq == SEQ_FLASH && r.count == 15'h0000 |=> $stable(r.cur_now))
        else $error("current stepped without a flash count");
    chk_step_rises: assert property (r.seq == SEQ_FLASH && r.count != 15'h0000 |=> r.cur_now >= $past(r.cur_now))
        else $error("current fell inside a counted sequence");
    chk_cause_drops: assert property (cause |=> !buck_en_o && !boost_en_o)
        else $error("converter enabled under a shutdown cause");
    chk_period_set: assert property (r.div_cnt == 5'h01 |=> r.period != 16'h0000)
        else $error("frame period left at zero");
endmodule

// [tb/lfs_trig_src.sv]
/*
 * trigger source model: a camera or pulse generator on the trigger line.
 * assumes fire_i and hold_i change just after rising edges of clk_i.
 */
module lfs_trig_src (
    input  wire logic clk_i,
    input  wire logic fire_i,
    input  wire logic hold_i,
    output logic      trig_n_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] low_cnt = 3'h0;
    // a fire request gives a four-cycle low pulse
    always_ff @(posedge clk_i) begin
        low_cnt <= fire_i ? 3'h4 : (low_cnt != 3'h0 ? low_cnt - 3'h1 : 3'h0);
    end
    // line idles high, low level or falling edge is the trigger
    assign trig_n_o = !(hold_i || low_cnt != 3'h0);
endmodule

// [tb/tb.sv]
/*
 * self-checking bench of the led flash sequencer.
 * assumes lfs_pkg and the trigger source model are compiled first.
 */
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import lfs_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    lfs_wb_req_t req = '0;
    lfs_wb_rsp_t rsp;
    logic        trig_n, fire = 1'b0, hold = 1'b0, bov = 1'b0, kov = 1'b0;
    logic        buv = 1'b0, fuse_n = 1'b1, sup = 1'b0, boost_en, buck_en, lsw;
    logic [3:0]  alert_n = 4'hf;
    logic [11:0] cur, fc;
    logic [31:0] q;
    int          error_cnt = 0, cmp_count = 0, cyc_cnt = 0, w, t0, t1;
    // clock and hang limit
    always #25 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 30000) begin
            error_cnt++;
            wrap_up();
        end
    end
    lfs_sequencer #(.STABLE_CYCLES(20)) lfs_sequencer_inst (
        .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp), .trig_n_i(trig_n),
        .temp_alert_n_i(alert_n), .boost_ov_i(bov), .buck_ov_i(kov), .boost_uv_i(buv),
        .fuse_fault_n_i(fuse_n), .supply_ok_i(sup), .boost_en_o(boost_en), .buck_en_o(buck_en),
        .load_sw_en_o(lsw), .led_current_o(cur));
    lfs_trig_src lfs_trig_src_inst (.clk_i(clk_i), .fire_i(fire), .hold_i(hold), .trig_n_o(trig_n));
    // helpers: verdict, compare, wait, bus cycle, flash measure
    task automatic wrap_up();
        $display("errors %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        req <= '{1'b1, 1'b1, wr, a, 4'hf, d};
        do begin
            @(posedge clk_i);
        end while (rsp.ack !== 1'b1);
        q = rsp.dat;
        req <= '0;
    endtask
    task automatic flash(input int lim);
        int n;
        n = 0;
        w = 0;
        while (buck_en !== 1'b1 && n < lim) begin
            @(posedge clk_i);
            n++;
        end
        t0 = cyc_cnt;
        fc = cur;
        while (buck_en === 1'b1 && w < 200) begin
            @(posedge clk_i);
            w++;
        end
    endtask
    // reset values, load switch delay, continuous light
    task automatic t_base();
        chk("buck_rst", 0, buck_en);
        wb(0, ADR_CUR, 0);
        chk("cur_rst", 200, q);
        wb(0, 8'h40, 0);
        chk("unmapped", 0, q);
        sup <= 1'b1;
        cyc(10);
        chk("lsw_early", 0, lsw);
        cyc(20);
        chk("lsw_on", 1, lsw);
        wb(1, ADR_CUR, 2000);
        cyc(5);
        chk("buck_off", 0, buck_en);
        wb(1, ADR_CTRL, 1);
        cyc(4);
        chk("buck_cont", 1, buck_en);
        chk("cur_cont", 500, cur);
    endtask
    // each shutdown cause drops light, is recorded, cleared by off to on
    task automatic t_fault();
        for (int i = 0; i < 3; i++) begin
            alert_n <= (i == 0) ? 4'hb : 4'hf;
            buv <= (i == 1);
            fuse_n <= (i != 2);
            cyc(3);
            chk("buck_fault", 0, buck_en);
            wb(0, ADR_STATUS, 0);
            chk("fail_code", i + 1, q[9:8]);
            chk("live_flags", (i == 0) ? 2 : (i == 2) ? 4 : 0, {q[3], q[0], 1'b0});
            alert_n <= 4'hf;
            buv <= 1'b0;
            fuse_n <= 1'b1;
            wb(1, ADR_CTRL, 0);
            wb(1, ADR_CTRL, 1);
            wb(0, ADR_STATUS, 0);
            chk("fail_clr", 0, q[9:8]);
        end
        bov <= 1'b1;
        kov <= 1'b1;
        cyc(1);
        bov <= 1'b0;
        kov <= 1'b0;
        cyc(3);
        chk("buck_ovp", 0, buck_en);
        wb(0, ADR_STATUS, 0);
        chk("ovp_flags", 3, q[2:1]);
        wb(1, ADR_CTRL, 32'h101);
        wb(0, ADR_STATUS, 0);
        chk("ovp_clr", 0, q[2:1]);
        wb(1, ADR_CTRL, 0);
    endtask
    // counted internal flashes, then external, source lock, switched
    task automatic t_flash();
        wb(1, ADR_RATE, 100000);
        wb(1, ADR_COUNT, 2);
        wb(1, ADR_ONTIME, 20);
        wb(1, ADR_CTRL, 1);
        flash(2500);
        t1 = t0;
        chk("width1", 20, w);
        flash(2500);
        chk("width2", 20, w);
        chk("period", 2000, t0 - t1);
        flash(2500);
        chk("no_third", 0, w);
        wb(1, ADR_CTRL, 0);
        wb(1, ADR_COUNT, 0);
        wb(1, ADR_CTRL, 2);
        wb(1, ADR_CTRL, 3);
        fire <= 1'b1;
        cyc(1);
        fire <= 1'b0;
        flash(10);
        chk("ext_width", 20, w);
        wb(1, ADR_CTRL, 1);
        wb(0, ADR_CTRL, 0);
        chk("src_lock", 1, q[1]);
        wb(1, ADR_CTRL, 2);
        wb(1, ADR_RATE, 0);
        wb(1, ADR_CTRL, 3);
        hold <= 1'b1;
        cyc(4);
        chk("sw_on", 1, buck_en);
        hold <= 1'b0;
        cyc(4);
        chk("sw_off", 0, buck_en);
    endtask
    // period rounding, rate clamp, half-stop bracketing with current step
    task automatic t_brk();
        int bw [5] = '{20, 28, 40, 56, 80};
        wb(1, ADR_CTRL, 0);
        wb(1, ADR_RATE, 7);
        cyc(20);
        wb(0, ADR_PERIOD, 0);
        chk("period_round", 14286, q);
        wb(1, ADR_RATE, 1);
        wb(0, ADR_RATE, 0);
        chk("rate_clamp", 2, q);
        wb(1, ADR_ONTIME, 40);
        wb(1, ADR_COUNT, 5);
        wb(1, ADR_STEP, 100);
        wb(1, ADR_CUR, 200);
        wb(1, ADR_CTRL, 32'hf);
        for (int k = 0; k < 6; k++) begin
            if (k == 5) begin
                wb(0, ADR_STATUS, 0);
                chk("brk_idle", 0, q[5]);
            end
            fire <= 1'b1;
            cyc(1);
            fire <= 1'b0;
            flash(10);
            chk("brk_width", bw[k % 5], w);
            chk("brk_cur", 200 + 100 * (k % 5), fc);
        end
    endtask
    // main sequence
    initial begin
        cyc(12);
        rst_i <= 1'b0;
        t_base();
        t_fault();
        t_flash();
        t_brk();
        wrap_up();
    end
endmodule
